/* File: core/fdr_regs.sv */
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`include "fdr_defs.svh"

module fdr_regs #(
  parameter logic [7:0] MAKER_ID = 8'hA5, // Arbitrary value
  parameter logic [3:0] VERSION_NIBBLE = 4'h3, // Arbitrary value
  parameter logic [3:0] STEPPING_NIBBLE = 4'h1 // Arbitrary value
) (
  input wire logic mclk_i, // Device clock, 20 MHz
  input wire logic rst_i, // Async reset, high
  input wire logic psel_i, // APB select
  input wire logic penable_i, // APB enable
  input wire logic pwrite_i, // APB direction
  input wire logic [`FDR_ADDR_W-1:0] paddr_i, // APB byte address
  input wire logic [31:0] pwdata_i, // APB write data
  output logic pready_o, // APB ready
  output logic [31:0] prdata_o, // APB read data
  output logic pslverr_o, // APB error, unmapped address
  input wire logic [2:0][7:0] auto_duty_i, // Algorithm duty per fan
  input wire logic [2:0] spinup_i, // Fan in spin-up phase
  output logic [2:0] pwm_o // Fan pulse outputs
);

  logic start;
  logic lock;
  logic ovrd;
  logic [2:0] manual;
  fdr_pkg::fdr_duty_t shadow [3];
  fdr_pkg::fdr_duty_t rd_copy [3];
  fdr_pkg::fdr_duty_t drive [3];
  fdr_pkg::fdr_duty_t driven [3];
  logic [2:0] per_start;
  logic [31:0] next_rdata;
  logic access;
  logic done;
  logic wr_done;
  fdr_pkg::fdr_reg_e sel;
  fdr_pkg::fdr_fan_t fan;

  function automatic fdr_pkg::fdr_reg_e reg_of(input logic [`FDR_ADDR_W-1:0] a);
    logic [7:0] idx;
    idx = a[`FDR_IDX_MSB:`FDR_IDX_LSB];
    if (a[1:0] != 2'b00 || a[`FDR_ADDR_W-1:`FDR_IDX_MSB+1] != 2'b00) begin
      reg_of = fdr_pkg::FDR_REG_NONE;
    end else if (idx >= `FDR_IDX_DUTY1 && idx <= `FDR_IDX_DUTY3) begin
      reg_of = fdr_pkg::FDR_REG_DUTY;
    end else if (idx == `FDR_IDX_MAKER) begin
      reg_of = fdr_pkg::FDR_REG_MAKER;
    end else if (idx == `FDR_IDX_REV) begin
      reg_of = fdr_pkg::FDR_REG_REV;
    end else if (idx == `FDR_IDX_CTRL) begin
      reg_of = fdr_pkg::FDR_REG_CTRL;
    end else if (idx == `FDR_IDX_MODE) begin
      reg_of = fdr_pkg::FDR_REG_MODE;
    end else begin
      reg_of = fdr_pkg::FDR_REG_NONE;
    end
  endfunction : reg_of

  // Fan number only means something for duty indices; other registers ignore it
  function automatic fdr_pkg::fdr_fan_t fan_of(input logic [`FDR_ADDR_W-1:0] a);
    logic [7:0] off;
    off = a[`FDR_IDX_MSB:`FDR_IDX_LSB] - `FDR_IDX_DUTY1;
    fan_of = off[1:0];
  endfunction : fan_of

  assign sel = reg_of(paddr_i);
  assign fan = fan_of(paddr_i);
  assign access = psel_i && penable_i;
  // pready is high for one cycle; the transfer completes at that edge
  assign done = access && pready_o;
  assign wr_done = done && pwrite_i;

  // APB answer: one wait cycle, then registered data and ready
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pready_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else if (access && !pready_o) begin
      pready_o <= 1'b1;
      prdata_o <= pwrite_i ? 32'h0000_0000 : next_rdata;
      pslverr_o <= (sel == fdr_pkg::FDR_REG_NONE);
    end else begin
      pready_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end
  end

  // Start and override stay writable under lock; lock only ever sets
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      start <= 1'b0;
      ovrd <= 1'b0;
    end else if (wr_done && sel == fdr_pkg::FDR_REG_CTRL) begin
      start <= pwdata_i[`FDR_BIT_START];
      ovrd <= pwdata_i[`FDR_BIT_OVRD];
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      lock <= 1'b0;
    end else if (wr_done && sel == fdr_pkg::FDR_REG_CTRL && pwdata_i[`FDR_BIT_LOCK]) begin
      lock <= 1'b1;
    end
  end

  // Mode selection is a parameter register and freezes with the lock
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      manual <= 3'b000;
    end else if (wr_done && sel == fdr_pkg::FDR_REG_MODE && !lock) begin
      manual <= pwdata_i[2:0];
    end
  end

  // Write-only copy: held whatever the mode, used only when manual and started
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < 3; i++) begin
        shadow[i] <= `FDR_DUTY_FULL;
      end
    end else if (wr_done && sel == fdr_pkg::FDR_REG_DUTY && !lock) begin
      shadow[fan] <= pwdata_i[7:0];
    end
  end

  // Duty source per fan
  // Override and a stopped monitor win over both manual and automatic sources
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (!start || ovrd) begin
        drive[i] = `FDR_DUTY_FULL;
      end else if (manual[i]) begin
        drive[i] = shadow[i];
      end else begin
        drive[i] = auto_duty_i[i];
      end
    end
  end

  for (genvar g = 0; g < 3; g++) begin : gen_fan
    fdr_pwm_gen u_pwm (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .duty_i(drive[g]),
      .per_start_o(per_start[g]),
      .duty_o(driven[g]),
      .pwm_o(pwm_o[g])
    );
  end

  // Read-only copy follows the pin but reads zero in spin-up, so a readback lags a write by up to a period
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < 3; i++) begin
        rd_copy[i] <= `FDR_DUTY_FULL;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (per_start[i]) begin
          rd_copy[i] <= spinup_i[i] ? `FDR_DUTY_ZERO : drive[i];
        end
      end
    end
  end

  // Read mux; reserved bits read zero, writes to identity registers fall away
  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (sel)
      fdr_pkg::FDR_REG_DUTY: begin
        next_rdata[7:0] = (fan == 2'd3) ? `FDR_DUTY_ZERO : rd_copy[fan];
      end
      fdr_pkg::FDR_REG_MAKER: begin
        next_rdata[7:0] = MAKER_ID;
      end
      fdr_pkg::FDR_REG_REV: begin
        next_rdata[7:0] = {VERSION_NIBBLE, STEPPING_NIBBLE};
      end
      fdr_pkg::FDR_REG_CTRL: begin
        next_rdata[`FDR_BIT_START] = start;
        next_rdata[`FDR_BIT_LOCK] = lock;
        next_rdata[`FDR_BIT_READY] = 1'b1;
        next_rdata[`FDR_BIT_OVRD] = ovrd;
      end
      fdr_pkg::FDR_REG_MODE: begin
        next_rdata[2:0] = manual;
      end
      fdr_pkg::FDR_REG_NONE: begin
        next_rdata = 32'h0000_0000;
      end
      default: begin
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  stop_full_a: assert property (
    !start |-> (drive[0] == `FDR_DUTY_FULL && drive[1] == `FDR_DUTY_FULL
      && drive[2] == `FDR_DUTY_FULL))
    else $error("stopped monitoring did not force full duty");

  manual_src_a: assert property (
    (start && !ovrd && manual[1]) |-> drive[1] == shadow[1])
    else $error("manual fan not driven from shadow");

  auto_src_a: assert property (
    (start && !ovrd && !manual[2]) |-> drive[2] == auto_duty_i[2])
    else $error("automatic fan not driven from algorithm");

  lock_write_a: assert property (
    (lock && wr_done && sel == fdr_pkg::FDR_REG_DUTY)
      |=> $stable(shadow[0]) && $stable(shadow[1]) && $stable(shadow[2]))
    else $error("duty write taken while locked");

  shadow_take_a: assert property (
    (!lock && wr_done && sel == fdr_pkg::FDR_REG_DUTY && fan == 2'd0)
      |=> shadow[0] == $past(pwdata_i[7:0]))
    else $error("duty write not held in shadow");

  lock_stick_a: assert property (
    lock |=> lock)
    else $error("lock bit cleared");

  read_lag_a: assert property (
    (per_start[0] && !spinup_i[0])
      |=> rd_copy[0] == $past(drive[0]) ##0 driven[0] == rd_copy[0])
    else $error("read copy not loaded from driven duty");

  spin_zero_a: assert property (
    (per_start[1] && spinup_i[1]) |=> rd_copy[1] == `FDR_DUTY_ZERO)
    else $error("spin-up duty not reported as zero");

  rev_read_a: assert property (
    (done && !pwrite_i && sel == fdr_pkg::FDR_REG_REV)
      |-> prdata_o == {24'h00_0000, VERSION_NIBBLE, STEPPING_NIBBLE})
    else $error("revision register read wrong value");

  id_read_a: assert property (
    (done && !pwrite_i && sel == fdr_pkg::FDR_REG_MAKER)
      |-> prdata_o == {24'h00_0000, MAKER_ID})
    else $error("maker identity read wrong value");

  apb_pulse_a: assert property (
    (access && !pready_o) |=> pready_o ##1 !pready_o)
    else $error("ready not a one-cycle answer");

  manual_first_a: assert property (
    (start && !ovrd && manual[0]) |-> drive[0] == shadow[0])
    else $error("manual first fan not driven from shadow");

  auto_first_a: assert property (
    (start && !ovrd && !manual[0]) |-> drive[0] == auto_duty_i[0])
    else $error("automatic first fan not driven from algorithm");

  ovrd_full_a: assert property (
    ovrd |-> (drive[0] == `FDR_DUTY_FULL && drive[1] == `FDR_DUTY_FULL
      && drive[2] == `FDR_DUTY_FULL))
    else $error("override did not force full duty");

  mode_lock_a: assert property (
    (lock && wr_done && sel == fdr_pkg::FDR_REG_MODE) |=> $stable(manual))
    else $error("mode write taken while locked");

  duty_read_a: assert property (
    (done && !pwrite_i && sel == fdr_pkg::FDR_REG_DUTY && fan == 2'd0)
      |-> prdata_o[7:0] == $past(rd_copy[0]))
    else $error("duty read not from read copy");

  err_unmapped_a: assert property (
    (done && sel == fdr_pkg::FDR_REG_NONE) |-> pslverr_o)
    else $error("unmapped access without error");

  ready_idle_a: assert property (
    !access |=> !pready_o)
    else $error("ready without a transfer");

endmodule : fdr_regs

/* File: core/fdr_defs.svh */
`ifndef FDR_DEFS_SVH
`define FDR_DEFS_SVH

// Register indices; byte address is four times the index
`define FDR_IDX_DUTY1 8'h30
`define FDR_IDX_DUTY2 8'h31
`define FDR_IDX_DUTY3 8'h32
`define FDR_IDX_MAKER 8'h3E
`define FDR_IDX_REV 8'h3F
`define FDR_IDX_CTRL 8'h40
`define FDR_IDX_MODE 8'h48

// APB address layout
`define FDR_ADDR_W 12
`define FDR_IDX_LSB 2
`define FDR_IDX_MSB 9

// Duty codes
`define FDR_DUTY_FULL 8'hFF
`define FDR_DUTY_HALF 8'h80
`define FDR_DUTY_ZERO 8'h00

// Control register bit positions
`define FDR_BIT_START 0
`define FDR_BIT_LOCK 1
`define FDR_BIT_READY 2
`define FDR_BIT_OVRD 3

// Pulse period: counter wraps after this value
`define FDR_PER_LAST 8'hFF
`define FDR_PER_PRELAST 8'hFE

`endif

/* File: core/fdr_pkg.sv */
package fdr_pkg;

  typedef logic [7:0] fdr_duty_t;

  typedef logic [1:0] fdr_fan_t;

  typedef enum logic [2:0] {
    FDR_REG_NONE,
    FDR_REG_DUTY,
    FDR_REG_MAKER,
    FDR_REG_REV,
    FDR_REG_CTRL,
    FDR_REG_MODE
  } fdr_reg_e;

endpackage : fdr_pkg

/* File: core/fdr_pwm_gen.sv */
`timescale 1ns/1ps
`include "fdr_defs.svh"

module fdr_pwm_gen (
  input wire logic mclk_i, // Device clock
  input wire logic rst_i, // Async reset, high
  input wire fdr_pkg::fdr_duty_t duty_i, // Duty to drive next period
  output logic per_start_o, // High in the last cycle of a period
  output fdr_pkg::fdr_duty_t duty_o, // Duty driven this period
  output logic pwm_o // Pulse output
);

  logic [7:0] cnt;
  logic [7:0] next_cnt;
  fdr_pkg::fdr_duty_t next_duty;

  assign per_start_o = (cnt == `FDR_PER_LAST);
  assign next_cnt = cnt + 8'h01;
  // Duty only changes on a period boundary so no pulse is ever cut short
  assign next_duty = per_start_o ? duty_i : duty_o;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= 8'h00;
    end else begin
      cnt <= next_cnt;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      duty_o <= `FDR_DUTY_FULL;
      pwm_o <= 1'b1;
    end else begin
      duty_o <= next_duty;
      // Full code gives 255 high and 1 low per 256-clock period
      pwm_o <= (next_cnt < next_duty);
    end
  end

  pwm_full_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (per_start_o && duty_o == `FDR_DUTY_FULL) |-> !pwm_o)
    else $error("full duty did not go low in last clock");

  pwm_half_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (duty_o == `FDR_DUTY_HALF && cnt == 8'h80 && !per_start_o)
      |-> !pwm_o ##0 $past(pwm_o))
    else $error("half duty edge at wrong count");

endmodule : fdr_pwm_gen

/* File: verification/fdr_host.sv */
`timescale 1ns/1ps
module fdr_host (
  input wire logic mclk_i, // Bus clock
  input wire logic pready_i, // Slave ready
  input wire logic [31:0] prdata_i, // Read data
  input wire logic pslverr_i, // Slave error
  output logic psel_o, // Select
  output logic penable_o, // Enable
  output logic pwrite_o, // Direction
  output logic [11:0] paddr_o, // Byte address
  output logic [31:0] pwdata_o // Write data
);
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = '0;
    pwdata_o = '0;
  end
  // Host runs one APB transfer per call and returns the read data and the error flag
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic e);
    @(posedge mclk_i);
    psel_o <= 1'b1;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge mclk_i);
    penable_o <= 1'b1;
    // Only the bench watchdog ends a wait that never sees ready
    do begin
      @(posedge mclk_i);
    end while (pready_i !== 1'b1);
    r = prdata_i;
    e = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    // Released lines must not keep showing the last request
    paddr_o <= ~a;
    pwdata_o <= ~d;
  endtask : xfer
endmodule : fdr_host

/* File: verification/tb.sv */
`timescale 1ns/1ps
`include "fdr_defs.svh"
module tb;
  localparam logic [7:0] MK = 8'hC3; // Arbitrary value
  localparam logic [3:0] VN = 4'h2; // Arbitrary value
  localparam logic [3:0] SN = 4'h7; // Arbitrary value
  logic clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0][7:0] auto_duty;
  logic [2:0] spinup, pwm;
  logic [31:0] seed = 32'h16A5D976;
  int miscompares, checks_done, shadow[3], mode, start, lock, ovrd;
  int codes[$] = '{`FDR_DUTY_ZERO, `FDR_DUTY_HALF, `FDR_DUTY_FULL};

  fdr_regs #(.MAKER_ID(MK), .VERSION_NIBBLE(VN), .STEPPING_NIBBLE(SN)) i_fdr_regs (.mclk_i(clk), .rst_i(rst),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready),
    .prdata_o(prdata), .pslverr_o(pslverr), .auto_duty_i(auto_duty), .spinup_i(spinup), .pwm_o(pwm));
  fdr_host i_fdr_host (.mclk_i(clk), .pready_i(pready), .prdata_i(prdata), .pslverr_i(pslverr), .psel_o(psel),
    .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata));

  function automatic logic [7:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction : rnd

  function automatic logic [11:0] ra(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction : ra

  // Duty the model expects on each pin
  function automatic int drv(input int i);
    if (start == 0 || ovrd != 0) return 255;
    return mode[i] ? shadow[i] : int'(auto_duty[i]);
  endfunction : drv

  task automatic chk_data(input string what, input logic [31:0] ex, input logic [31:0] got);
    checks_done++;
    if (got !== ex) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, ex, got);
    end
  endtask : chk_data

  task automatic chk_cnt(input int ex, input int got);
    checks_done++;
    if (got != ex) begin
      miscompares++;
      $display("mismatch pwm high count expected %0d seen %0d", ex, got);
    end
  endtask : chk_cnt

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    i_fdr_host.xfer(1'b1, ra(idx), {24'h0, d}, r, e);
    chk_data("write error", 32'h0, {31'h0, e});
    if (lock == 0 && idx >= `FDR_IDX_DUTY1 && idx <= `FDR_IDX_DUTY3) shadow[idx - `FDR_IDX_DUTY1] = d;
    if (lock == 0 && idx == `FDR_IDX_MODE) mode = d[2:0];
    if (idx == `FDR_IDX_CTRL) begin
      start = d[0];
      ovrd = d[3];
      lock = lock | d[1];
    end
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [7:0] ex, input string what);
    logic [31:0] r;
    logic e;
    i_fdr_host.xfer(1'b0, ra(idx), 32'h0, r, e);
    chk_data(what, {24'h0, ex}, r);
    chk_data("read error", 32'h0, {31'h0, e});
  endtask : rd

  task automatic bad(input logic [11:0] a);
    logic [31:0] r;
    logic e;
    i_fdr_host.xfer(1'b0, a, 32'h0, r, e);
    chk_data("unmapped data", 32'h0, r);
    chk_data("unmapped error", 32'h1, {31'h0, e});
  endtask : bad

  // Two periods let both the driven and the read copy catch up
  task automatic settle(input string name);
    int cnt[3];
    repeat (520) @(posedge clk);
    for (int i = 0; i < 3; i++) rd(`FDR_IDX_DUTY1 + 8'(i), 8'(spinup[i] ? 0 : drv(i)), "duty");
    repeat (256) begin
      @(negedge clk);
      // An unknown pin level pushes the count out of range
      for (int i = 0; i < 3; i++) cnt[i] += (pwm[i] === 1'b1) ? 1 : (pwm[i] === 1'b0) ? 0 : 512;
    end
    for (int i = 0; i < 3; i++) chk_cnt(drv(i), cnt[i]);
    $display("test %s done", name);
    @(posedge clk);
  endtask : settle

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    $display("watchdog expired");
    results();
  end

  initial begin
    rst = 1'b1;
    auto_duty = '0;
    spinup = '0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    settle("reset");
    rd(`FDR_IDX_CTRL, 8'h04, "control");
    wr(`FDR_IDX_MAKER, rnd());
    wr(`FDR_IDX_REV, rnd());
    rd(`FDR_IDX_MAKER, MK, "maker");
    rd(`FDR_IDX_REV, {VN, SN}, "revision");
    bad(12'h004);
    bad(12'h0C1);
    bad(12'h4C0);
    for (int i = 0; i < 3; i++) wr(`FDR_IDX_DUTY1 + 8'(i), rnd());
    settle("stopped");
    wr(`FDR_IDX_MODE, 8'h07);
    settle("manual stopped");
    wr(`FDR_IDX_CTRL, 8'h01);
    settle("manual started");
    for (int i = 0; i < 3; i++) wr(`FDR_IDX_DUTY1 + 8'(i), 8'(codes[i]));
    settle("codes");
    auto_duty <= {rnd(), rnd(), rnd()};
    wr(`FDR_IDX_MODE, 8'h02);
    wr(`FDR_IDX_DUTY1, rnd());
    settle("mixed");
    spinup <= 3'b110;
    settle("spin-up");
    spinup <= 3'b000;
    wr(`FDR_IDX_MODE, 8'h07);
    wr(`FDR_IDX_CTRL, 8'h03);
    for (int i = 0; i < 3; i++) wr(`FDR_IDX_DUTY1 + 8'(i), rnd());
    wr(`FDR_IDX_CTRL, 8'h01);
    wr(`FDR_IDX_MODE, 8'h00);
    settle("locked");
    rd(`FDR_IDX_CTRL, 8'h07, "control");
    wr(`FDR_IDX_CTRL, 8'h09);
    settle("override");
    rd(`FDR_IDX_CTRL, 8'h0F, "control");
    results();
  end
endmodule : tb
